// ===== hw/bmc_pkg.sv
// Purpose: constants and types for the buck modulation mode controller
// Assumes: 50 MHz system clock
// Notes:   lag times are typical figures, counted in system clock cycles
package bmc_pkg;

   localparam int unsigned CLK_HZ         = 50_000_000;
   localparam int unsigned LAG_LONG_US    = 1000;
   localparam int unsigned LAG_SHORT_US   = 100;
   localparam int unsigned LAG_LONG_CYC   = LAG_LONG_US * (CLK_HZ / 1_000_000);
   localparam int unsigned LAG_SHORT_CYC  = LAG_SHORT_US * (CLK_HZ / 1_000_000);
   localparam int unsigned LAG_W          = 16;

   localparam logic        AUTO_EN_RST    = 1'b0;
   localparam logic        WAKE_SEL_RST   = 1'b0;
   localparam logic        LAG_SEL_RST    = 1'b0;

   // host mode commands
   typedef enum logic [2:0] {
      BMC_CMD_NORMAL,
      BMC_CMD_STOP,
      BMC_CMD_SLEEP,
      BMC_CMD_FAILSAFE
   } bmc_cmd_t;

   typedef enum logic [2:0] {
      BMC_ST_NORMAL,
      BMC_ST_STOP,
      BMC_ST_SLEEP,
      BMC_ST_FAILSAFE,
      BMC_ST_RESTART
   } bmc_state_t;

endpackage

// ===== hw/bmc_ctrl.sv
// Purpose: buck modulation and operating mode control
// Assumes: all inputs synchronous to sys_clk; commands are one-cycle strobes
// Notes:   analog regulation stays outside; this block only decides modes
`timescale 1ns/100ps
`default_nettype none

module bmc_ctrl
   import bmc_pkg::*;
#(
   parameter int unsigned LAG_LONG  = LAG_LONG_CYC,
   parameter int unsigned LAG_SHORT = LAG_SHORT_CYC
)(
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       cmd_valid,
   input  wire bmc_cmd_t   cmd_code,
   input  wire logic       auto_pwm_enable,
   input  wire logic       wake_pin_modulation_select,
   input  wire logic       lag_time_select,
   input  wire logic       boost_enable,
   input  wire logic       wake_input_pin,
   input  wire logic       bus_wake,
   input  wire logic       auto_switch_current_threshold,
   input  wire logic       supply_below_boost_th,
   input  wire logic       buck_above_reset_th,
   input  wire logic       auto_switch_flag_clear,
   output logic            buck_enable,
   output logic            buck_pwm,
   output logic            boost_run,
   output logic            stop_current_limit,
   output logic            interrupt_out_n,
   output logic            reset_out_n,
   output logic            auto_switch_flag,
   output bmc_state_t      mode_state
);

   initial begin
      if (LAG_LONG < 1 || LAG_SHORT < 1 || LAG_LONG >= (1 << LAG_W) || LAG_SHORT >= (1 << LAG_W))
         $error("lag counts out of range");
   end

   bmc_state_t        state_r;
   bmc_state_t        state_nxt;
   logic [LAG_W-1:0]  lag_cnt_r;
   logic              lag_done_r;
   logic              promoted_r;
   logic              boost_cfg_r;
   logic              pwm_nxt;

   function automatic logic buck_on(input bmc_state_t s);
      buck_on = (s == BMC_ST_NORMAL) || (s == BMC_ST_STOP) || (s == BMC_ST_RESTART);
   endfunction

   wire stop_cmd  = cmd_valid && (cmd_code == BMC_CMD_STOP);
   wire auto_mode = auto_pwm_enable;
   wire wake_mode = wake_pin_modulation_select && !auto_pwm_enable;
   // lag ends on the cycle the count reaches zero, so PWM stands exactly the lag count
   wire lag_end   = lag_done_r || (lag_cnt_r == '0);
   // a Stop command in the same cycle restarts the lag, so it must not promote
   wire promote   = (state_r == BMC_ST_STOP) && auto_mode && lag_end && !stop_cmd
                    && auto_switch_current_threshold && !promoted_r;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         BMC_ST_NORMAL, BMC_ST_STOP: begin
            if (cmd_valid) begin
               case (cmd_code)
                  BMC_CMD_NORMAL:   state_nxt = BMC_ST_NORMAL;
                  BMC_CMD_STOP:     state_nxt = BMC_ST_STOP;
                  BMC_CMD_SLEEP:    state_nxt = BMC_ST_SLEEP;
                  BMC_CMD_FAILSAFE: state_nxt = BMC_ST_FAILSAFE;
                  default:          state_nxt = state_r;
               endcase
            end
         end
         BMC_ST_SLEEP, BMC_ST_FAILSAFE: begin
            if (wake_input_pin || bus_wake)
               state_nxt = BMC_ST_RESTART;
         end
         BMC_ST_RESTART: begin
            if (buck_above_reset_th)
               state_nxt = BMC_ST_NORMAL;
         end
         default: state_nxt = BMC_ST_RESTART;
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst)
         state_r <= BMC_ST_RESTART;
      else
         state_r <= state_nxt;
   end

   // lag counter restarts on every Stop command accepted in Normal or Stop, including a repeat
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         lag_cnt_r  <= '0;
         lag_done_r <= 1'b0;
      end else if (state_nxt == BMC_ST_STOP && (stop_cmd || state_r != BMC_ST_STOP)) begin
         lag_cnt_r  <= lag_time_select ? LAG_W'(LAG_LONG - 1) : LAG_W'(LAG_SHORT - 1);
         lag_done_r <= 1'b0;
      end else if (state_r == BMC_ST_STOP && !lag_done_r) begin
         if (lag_cnt_r == '0)
            lag_done_r <= 1'b1;
         else
            lag_cnt_r <= lag_cnt_r - 1'b1;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst)
         promoted_r <= 1'b0;
      else if (stop_cmd || state_r != BMC_ST_STOP)
         promoted_r <= 1'b0;
      else if (promote)
         promoted_r <= 1'b1;
   end

   // modulation choice; outside wake-pin mode PWM holds through lag so the PFM change takes effect after it
   always_comb begin
      case (state_nxt)
         BMC_ST_NORMAL, BMC_ST_RESTART: pwm_nxt = 1'b1;
         BMC_ST_STOP: begin
            if (stop_cmd || state_r != BMC_ST_STOP)
               pwm_nxt = buck_pwm && !(wake_mode && !wake_input_pin);
            else if (wake_mode)
               pwm_nxt = wake_input_pin;
            else if (promote || promoted_r)
               pwm_nxt = 1'b1;
            else if (!lag_end)
               pwm_nxt = buck_pwm;
            else
               pwm_nxt = 1'b0;
         end
         default: pwm_nxt = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         buck_pwm           <= 1'b0;
         buck_enable        <= 1'b0;
         stop_current_limit <= 1'b0;
      end else begin
         buck_pwm           <= pwm_nxt;
         buck_enable        <= buck_on(state_nxt);
         stop_current_limit <= (state_nxt == BMC_ST_STOP) && !pwm_nxt;
      end
   end

   // boost config remembered from Normal so Restart can bring it back
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst)
         boost_cfg_r <= 1'b0;
      else if (state_r == BMC_ST_NORMAL)
         boost_cfg_r <= boost_enable;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst)
         boost_run <= 1'b0;
      else if (state_nxt == BMC_ST_SLEEP || state_nxt == BMC_ST_FAILSAFE)
         boost_run <= 1'b0;
      else if (state_nxt == BMC_ST_RESTART)
         boost_run <= boost_cfg_r && supply_below_boost_th;
      else
         boost_run <= boost_enable && supply_below_boost_th;
   end

   // interrupt event: one-cycle low pulse
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst)
         interrupt_out_n <= 1'b1;
      else
         interrupt_out_n <= !promote;
   end

   // set wins over a simultaneous clear
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst)
         auto_switch_flag <= 1'b0;
      else if (promote)
         auto_switch_flag <= 1'b1;
      else if (auto_switch_flag_clear)
         auto_switch_flag <= 1'b0;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst)
         reset_out_n <= 1'b0;
      else
         reset_out_n <= (state_nxt == BMC_ST_NORMAL || state_nxt == BMC_ST_STOP);
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst)
         mode_state <= BMC_ST_RESTART;
      else
         mode_state <= state_nxt;
   end

endmodule

`default_nettype wire

// ===== dv/bmc_chk_assertions.sv
// Purpose: port checker for bmc_ctrl
// Assumes: bench keeps the load low during lag
// Notes:   bound after the module
`timescale 1ns/100ps
`default_nettype none
module bmc_chk
   import bmc_pkg::*;
(
   input wire logic       sys_clk,
   input wire logic       rst,
   input wire logic       cmd_valid,
   input wire bmc_cmd_t   cmd_code,
   input wire logic       auto_pwm_enable,
   input wire logic       wake_pin_modulation_select,
   input wire logic       wake_input_pin,
   input wire logic       auto_switch_current_threshold,
   input wire logic       buck_above_reset_th,
   input wire logic       buck_enable,
   input wire logic       buck_pwm,
   input wire logic       boost_run,
   input wire logic       interrupt_out_n,
   input wire logic       reset_out_n,
   input wire logic       auto_switch_flag,
   input wire bmc_state_t mode_state
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence s_entry;
      mode_state == BMC_ST_NORMAL && cmd_valid && cmd_code == BMC_CMD_STOP && auto_pwm_enable;
   endsequence
   sequence s_stay;
      mode_state == BMC_ST_STOP && !cmd_valid;
   endsequence
   // 30 covers both lag selects at the cut lengths
   AST_LAG: assert property (s_entry |=> buck_pwm [*3] ##[1:30] !buck_pwm) else $error("lag");
   AST_PROMO: assert property (s_stay ##0 auto_pwm_enable && auto_switch_current_threshold && !buck_pwm
      |=> buck_pwm && !interrupt_out_n && auto_switch_flag ##1 interrupt_out_n) else $error("promotion");
   AST_WAKE: assert property (s_stay ##0 !auto_pwm_enable && wake_pin_modulation_select
      |=> buck_pwm == $past(wake_input_pin)) else $error("wake pin");
   AST_HOLD: assert property (s_stay ##0 !auto_pwm_enable && !wake_pin_modulation_select && !buck_pwm
      |=> !buck_pwm) else $error("pfm hold");
   AST_OFF: assert property (mode_state inside {BMC_ST_SLEEP, BMC_ST_FAILSAFE}
      |-> !buck_enable && !boost_run) else $error("off");
   AST_ON: assert property (mode_state inside {BMC_ST_NORMAL, BMC_ST_STOP} |-> buck_enable) else $error("on");
   AST_NORM: assert property (mode_state == BMC_ST_STOP && cmd_valid && cmd_code == BMC_CMD_NORMAL
      |=> mode_state == BMC_ST_NORMAL && buck_pwm) else $error("normal");
   AST_REL: assert property (mode_state == BMC_ST_RESTART && buck_above_reset_th
      |=> mode_state == BMC_ST_NORMAL && reset_out_n) else $error("release");
endmodule
bind bmc_ctrl bmc_chk u_chk (.*);
`default_nettype wire

// ===== dv/bmc_host.sv
// Purpose: host model issuing mode commands
// Assumes: one-cycle command strobe
// Notes:   config levels come from the bench
`timescale 1ns/100ps
`default_nettype none
module bmc_host
   import bmc_pkg::*;
(
   input wire logic sys_clk,
   output logic     cmd_valid,
   output bmc_cmd_t cmd_code
);
   initial begin
      cmd_valid = 1'b0;
      cmd_code  = BMC_CMD_NORMAL;
   end
   // stop only after the bench dropped the load
   task automatic send(bmc_cmd_t c);
      @(posedge sys_clk);
      #1 cmd_valid = 1'b1;
      cmd_code = c;
      @(posedge sys_clk);
      #1 cmd_valid = 1'b0;
   endtask
endmodule
`default_nettype wire

// ===== dv/test_buck_modulation_mode_control.sv
// Purpose: self-checking bench for bmc_ctrl
// Assumes: lag cut to 20 and 4 cycles
// Notes:   inputs move 1 ns after the edge
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
   $display("MISMATCH %0t got %0h exp %0h", $time, g, e); end end
module test_buck_modulation_mode_control;
   import bmc_pkg::*;
   logic sys_clk = 1'b0, rst = 1'b1, auto_pwm_enable = 1'b0, wake_pin_modulation_select = 1'b0;
   logic lag_time_select = 1'b0, boost_enable = 1'b1, wake_input_pin = 1'b0, bus_wake = 1'b0;
   logic auto_switch_current_threshold = 1'b0, supply_below_boost_th = 1'b1, buck_above_reset_th = 1'b1;
   logic auto_switch_flag_clear = 1'b0, cmd_valid, buck_enable, buck_pwm, boost_run, stop_current_limit;
   logic interrupt_out_n, reset_out_n, auto_switch_flag;
   bmc_cmd_t cmd_code;
   bmc_state_t mode_state;
   int mismatches = 0, n_tests = 0, c0, c1;
   bmc_host u_host (.*);
   bmc_ctrl #(.LAG_LONG(20), .LAG_SHORT(4)) u_dut (.*);
   always #10 sys_clk = ~sys_clk;
   task automatic tick(int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // bounded: a stuck modulation must not hang the run
   task automatic wait_pfm(output int cnt);
      for (cnt = 0; buck_pwm !== 1'b0 && cnt < 100; cnt++) tick(1);
      if (cnt == 100) begin
         mismatches++;
         end_sim();
      end
   endtask
   initial begin
      tick(3);
      rst = 1'b0;
      tick(2);
      `CHK({mode_state, reset_out_n, boost_run}, {BMC_ST_NORMAL, 2'b11})
      auto_pwm_enable = 1'b1;
      u_host.send(BMC_CMD_STOP);
      `CHK(buck_pwm, 1'b1)
      wait_pfm(c0);
      `CHK(c0, 4)
      `CHK(stop_current_limit, 1'b1)
      auto_switch_current_threshold = 1'b1;
      tick(1);
      `CHK({buck_pwm, interrupt_out_n, auto_switch_flag}, 3'b101)
      auto_switch_current_threshold = 1'b0;
      lag_time_select = 1'b1;
      tick(5);
      `CHK({buck_pwm, interrupt_out_n, auto_switch_flag}, 3'b111)
      u_host.send(BMC_CMD_STOP);
      wait_pfm(c1);
      `CHK(c1 - c0, 16)
      {auto_switch_flag_clear, wake_pin_modulation_select, wake_input_pin} = 3'b111;
      tick(2);
      `CHK({buck_pwm, auto_switch_flag}, 2'b00)
      {auto_switch_flag_clear, auto_pwm_enable} = 2'b00;
      tick(1);
      `CHK(buck_pwm, 1'b1)
      wake_input_pin = 1'b0;
      tick(1);
      `CHK(buck_pwm, 1'b0)
      {wake_pin_modulation_select, wake_input_pin} = 2'b01;
      tick(3);
      `CHK(buck_pwm, 1'b0)
      $display("stop tests done");
      u_host.send(BMC_CMD_NORMAL);
      `CHK({mode_state, buck_pwm, stop_current_limit, boost_run}, {BMC_ST_NORMAL, 3'b101})
      for (int i = 0; i < 2; i++) begin
         {buck_above_reset_th, wake_input_pin} = 2'b00;
         u_host.send(i ? BMC_CMD_FAILSAFE : BMC_CMD_SLEEP);
         `CHK({buck_enable, boost_run}, 2'b00)
         {wake_input_pin, bus_wake} = i ? 2'b10 : 2'b01;
         tick(1);
         {wake_input_pin, bus_wake} = 2'b00;
         `CHK({mode_state, buck_enable, boost_run, reset_out_n}, {BMC_ST_RESTART, 3'b110})
         buck_above_reset_th = 1'b1;
         tick(1);
         `CHK({mode_state, reset_out_n}, {BMC_ST_NORMAL, 1'b1})
      end
      $display("wake tests done");
      end_sim();
   end
endmodule
`default_nettype wire
